// ### prec_pkg.sv
// constants for the pulse reference and error clear block
// assumes a classic wishbone slave with 32-bit data at 100 MHz
// Summary of operation
// - digits 5/6: negative-logic sign-pulse, fwd/rev decoding
// - auto-clear 0: clear error on any baseblock
// - auto-clear 1: only external clear input clears
// - auto-clear 2: clear error only on alarm or external clear input
package prec_pkg;
    // register byte offsets
    localparam logic [7:0] PREC_OFS_SELECT = 8'h00;
    localparam logic [7:0] PREC_OFS_STATUS = 8'h04;
    // reset value of the select register (factory setting)
    localparam logic [11:0] PREC_SELECT_RST = 12'h000;
    // field positions inside the select register
    localparam int PREC_FMT_LSB = 0;
    localparam int PREC_CLR_LSB = 4;
    localparam int PREC_OP_LSB = 8;
    localparam int PREC_DIGIT_W = 4;
    localparam int PREC_SELECT_W = 12;
    // status field positions
    localparam int PREC_ST_CLR = 16;
    localparam int PREC_ST_BB = 17;
    localparam int PREC_ST_ALM = 18;
    // reference pulse format digit values
    localparam logic [3:0] PREC_FMT_SIGN_POS = 4'h0;
    localparam logic [3:0] PREC_FMT_FR_POS = 4'h1;
    localparam logic [3:0] PREC_FMT_SIGN_NEG = 4'h5;
    localparam logic [3:0] PREC_FMT_FR_NEG = 4'h6;
    // clear signal sensing digit values
    localparam logic [3:0] PREC_CLR_HIGH = 4'h0;
    localparam logic [3:0] PREC_CLR_RISE = 4'h1;
    localparam logic [3:0] PREC_CLR_LOW = 4'h2;
    localparam logic [3:0] PREC_CLR_FALL = 4'h3;
    // automatic clear operation digit values
    localparam logic [3:0] PREC_OP_BASEBLOCK = 4'h0;
    localparam logic [3:0] PREC_OP_NEVER = 4'h1;
    localparam logic [3:0] PREC_OP_ALARM = 4'h2;
endpackage

// ### prec_top.sv
// pulse reference decoder, position error counter and clear selection
// assumes pins synchronous to clk_i and a classic wishbone master
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module prec_top #(
    parameter int ERR_W = 16 // position error counter width
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // reference pulse pins from the host
    input wire logic ref_a_i,
    input wire logic ref_b_i,
    input wire logic clear_in_i,
    // drive state
    input wire logic baseblock_i,
    input wire logic alarm_i,
    input wire logic fb_up_i,
    input wire logic fb_dn_i,
    // results
    output logic signed [ERR_W-1:0] pos_err_o,
    output logic err_clear_o
);
    // select register and its digits
    logic [prec_pkg::PREC_SELECT_W-1:0] select_q;
    logic [3:0] fmt;
    logic [3:0] clr_form;
    logic [3:0] clr_op;
    // previous pin samples for edge detection
    logic a_prev_q;
    logic b_prev_q;
    logic clr_prev_q;
    // decoded reference steps
    logic ref_up;
    logic ref_dn;
    // clear requests
    logic ext_clr;
    logic auto_clr;
    logic clr_req;
    // error counter
    logic signed [ERR_W-1:0] err_q;
    logic signed [ERR_W-1:0] err_d;
    logic err_clear_q;
    // bus
    logic ack_q;
    logic [31:0] dat_q;
    logic bus_req;

    assign fmt = select_q[prec_pkg::PREC_FMT_LSB +: prec_pkg::PREC_DIGIT_W];
    assign clr_form = select_q[prec_pkg::PREC_CLR_LSB +: prec_pkg::PREC_DIGIT_W];
    assign clr_op = select_q[prec_pkg::PREC_OP_LSB +: prec_pkg::PREC_DIGIT_W];
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;

    // pin history, data only so no reset needed
    always_ff @(posedge clk_i) begin
        a_prev_q <= ref_a_i;
        b_prev_q <= ref_b_i;
        clr_prev_q <= clear_in_i;
    end

    // reference pulse decoding; two-phase formats are not decoded here
    always_comb begin
        ref_up = 1'b0;
        ref_dn = 1'b0;
        case (fmt)
            prec_pkg::PREC_FMT_SIGN_POS: begin
                // count rising pulse edges, sign high means reverse
                ref_up = ref_a_i & ~a_prev_q & ~ref_b_i;
                ref_dn = ref_a_i & ~a_prev_q & ref_b_i;
            end
            prec_pkg::PREC_FMT_FR_POS: begin
                ref_up = ref_a_i & ~a_prev_q;
                ref_dn = ref_b_i & ~b_prev_q;
            end
            prec_pkg::PREC_FMT_SIGN_NEG: begin
                // active-low pulses, sign low means forward
                ref_up = ~ref_a_i & a_prev_q & ~ref_b_i;
                ref_dn = ~ref_a_i & a_prev_q & ref_b_i;
            end
            prec_pkg::PREC_FMT_FR_NEG: begin
                // active-low forward and reverse trains
                ref_up = ~ref_a_i & a_prev_q;
                ref_dn = ~ref_b_i & b_prev_q;
            end
            default: begin
                // unsupported format counts nothing
                ref_up = 1'b0;
            end
        endcase
    end

    // external clear sensing; levels clear continuously
    always_comb begin
        case (clr_form)
            prec_pkg::PREC_CLR_HIGH: ext_clr = clear_in_i;
            prec_pkg::PREC_CLR_RISE: ext_clr = clear_in_i & ~clr_prev_q;
            prec_pkg::PREC_CLR_LOW: ext_clr = ~clear_in_i;
            prec_pkg::PREC_CLR_FALL: ext_clr = ~clear_in_i & clr_prev_q;
            default: ext_clr = 1'b0;
        endcase
    end

    // automatic clear; mode 0 ORs alarm in with the baseblock input
    always_comb begin
        case (clr_op)
            prec_pkg::PREC_OP_BASEBLOCK: auto_clr = baseblock_i | alarm_i;
            prec_pkg::PREC_OP_NEVER: auto_clr = 1'b0;
            prec_pkg::PREC_OP_ALARM: auto_clr = alarm_i;
            default: auto_clr = 1'b0; // reserved value behaves as never
        endcase
    end

    assign clr_req = ext_clr | auto_clr;

    // error counter next value; clear wins over any step
    always_comb begin
        err_d = err_q;
        if (clr_req) begin
            err_d = '0;
        end else begin
            // simultaneous steps all count, one unit each
            err_d = err_q + ERR_W'(ref_up) - ERR_W'(ref_dn)
                - ERR_W'(fb_up_i) + ERR_W'(fb_dn_i);
        end
    end

    // error counter and clear indication
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_q <= '0;
            err_clear_q <= 1'b0;
        end else begin
            err_q <= err_d;
            err_clear_q <= clr_req;
        end
    end

    assign pos_err_o = err_q;
    assign err_clear_o = err_clear_q;

    // select register write, byte lanes 0 and 1 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            select_q <= prec_pkg::PREC_SELECT_RST;
        end else if (bus_req && wb_we_i
                     && wb_adr_i == prec_pkg::PREC_OFS_SELECT) begin
            if (wb_sel_i[0]) begin
                select_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                select_q[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // one-cycle ack one edge after the strobe, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= bus_req;
            dat_q <= '0;
            // unmapped addresses still ack and read zero
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    prec_pkg::PREC_OFS_SELECT: begin
                        dat_q <= 32'(select_q);
                    end
                    prec_pkg::PREC_OFS_STATUS: begin
                        dat_q[ERR_W-1:0] <= err_q;
                        dat_q[prec_pkg::PREC_ST_CLR] <= err_clear_q;
                        dat_q[prec_pkg::PREC_ST_BB] <= baseblock_i;
                        dat_q[prec_pkg::PREC_ST_ALM] <= alarm_i;
                    end
                    default: begin
                        dat_q <= '0;
                    end
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // checks; all in the clk_i domain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // negative-logic sign plus pulse, forward step
    AST_SIGN_NEG_FWD: assert property (
        (fmt == prec_pkg::PREC_FMT_SIGN_NEG && $fell(ref_a_i) && !ref_b_i
         && !clr_req && !fb_up_i && !fb_dn_i)
        |=> (err_q == $past(err_q) + ERR_W'(1)))
        else $error("sign pulse forward step not counted");

    // negative-logic reverse train, reverse step
    AST_FR_NEG_REV: assert property (
        (fmt == prec_pkg::PREC_FMT_FR_NEG && $fell(ref_b_i)
         && !$fell(ref_a_i) && !clr_req && !fb_up_i && !fb_dn_i)
        |=> (err_q == $past(err_q) - ERR_W'(1)))
        else $error("reverse train step not counted");

    // rising-edge clear empties the counter
    AST_CLR_RISE: assert property (
        (clr_form == prec_pkg::PREC_CLR_RISE && $rose(clear_in_i))
        |=> (err_q == '0 && err_clear_o))
        else $error("rising clear edge missed");

    // low-level clear holds the counter at zero
    AST_CLR_LOW: assert property (
        (clr_form == prec_pkg::PREC_CLR_LOW && !clear_in_i) [*2]
        |=> (err_q == '0))
        else $error("low level clear not held");

    // baseblock clears in mode 0
    AST_BB_CLEAR: assert property (
        (clr_op == prec_pkg::PREC_OP_BASEBLOCK && baseblock_i)
        |=> (err_q == '0 && err_clear_o))
        else $error("baseblock did not clear error");

    // mode 1 never clears without the clear input
    AST_NEVER_AUTO: assert property (
        (clr_op == prec_pkg::PREC_OP_NEVER
         && clr_form == prec_pkg::PREC_CLR_HIGH && !clear_in_i)
        |=> !err_clear_o)
        else $error("automatic clear in never mode");

    // mode 2 clears on alarm
    AST_ALARM_CLEAR: assert property (
        (clr_op == prec_pkg::PREC_OP_ALARM && alarm_i)
        |=> (err_q == '0))
        else $error("alarm did not clear error");

    // mode 2 ignores a plain baseblock
    AST_ALARM_ONLY: assert property (
        (clr_op == prec_pkg::PREC_OP_ALARM && baseblock_i && !alarm_i
         && clr_form == prec_pkg::PREC_CLR_HIGH && !clear_in_i)
        |=> !err_clear_o)
        else $error("baseblock cleared in alarm-only mode");

    // negative-logic sign plus pulse, reverse step
    AST_SIGN_NEG_REV: assert property (
        (fmt == prec_pkg::PREC_FMT_SIGN_NEG && $fell(ref_a_i) && ref_b_i
         && !clr_req && !fb_up_i && !fb_dn_i)
        |=> (err_q == $past(err_q) - ERR_W'(1)))
        else $error("sign pulse reverse step not counted");

    // negative-logic forward train, forward step
    AST_FR_NEG_FWD: assert property (
        (fmt == prec_pkg::PREC_FMT_FR_NEG && $fell(ref_a_i)
         && !$fell(ref_b_i) && !clr_req && !fb_up_i && !fb_dn_i)
        |=> (err_q == $past(err_q) + ERR_W'(1)))
        else $error("forward train step not counted");

    // a rise is only the return to idle in negative logic, never a step
    AST_FR_NEG_RISE: assert property (
        (fmt == prec_pkg::PREC_FMT_FR_NEG && $rose(ref_a_i)
         && !$fell(ref_b_i) && !clr_req && !fb_up_i && !fb_dn_i)
        |=> (err_q == $past(err_q)))
        else $error("rising edge counted in negative logic");

    // high-level clear empties the counter
    AST_CLR_HIGH: assert property (
        (clr_form == prec_pkg::PREC_CLR_HIGH && clear_in_i)
        |=> (err_q == '0 && err_clear_o))
        else $error("high level clear missed");

    // falling-edge clear empties the counter
    AST_CLR_FALL: assert property (
        (clr_form == prec_pkg::PREC_CLR_FALL && $fell(clear_in_i))
        |=> (err_q == '0 && err_clear_o))
        else $error("falling clear edge missed");

    // alarm is a baseblock cause, so mode 0 clears on it too
    AST_BB_ALARM: assert property (
        (clr_op == prec_pkg::PREC_OP_BASEBLOCK && alarm_i)
        |=> (err_q == '0))
        else $error("alarm did not clear in baseblock mode");

    // mode 1 ignores baseblock and alarm alike
    AST_NEVER_BB: assert property (
        (clr_op == prec_pkg::PREC_OP_NEVER && (baseblock_i || alarm_i)
         && clr_form == prec_pkg::PREC_CLR_RISE && !$rose(clear_in_i))
        |=> !err_clear_o)
        else $error("baseblock cleared in never mode");

    // main scenarios
    COV_FWD_COUNT: cover property (
        fmt == prec_pkg::PREC_FMT_FR_NEG && ref_up ##1 err_q != '0);
    COV_FALL_CLEAR: cover property (
        clr_form == prec_pkg::PREC_CLR_FALL && $fell(clear_in_i));
    COV_ALARM_MODE: cover property (
        clr_op == prec_pkg::PREC_OP_ALARM && alarm_i);
    COV_BB_CLEAR: cover property (
        clr_op == prec_pkg::PREC_OP_BASEBLOCK && baseblock_i ##1 err_clear_o);
endmodule

// ### prec_host.sv
// host controller model: reference pulse trains and clear input
// assumes tasks are entered right after a rising clk_i edge
`timescale 1ns/100ps
module prec_host (
    // clock
    input wire logic clk_i,
    // pins to the drive
    output logic ref_a_o,
    output logic ref_b_o,
    output logic clear_o
);
    initial begin
        ref_a_o = 1'b0;
        ref_b_o = 1'b0;
        clear_o = 1'b0;
    end
    // park both trains at the idle level of the format
    task automatic idle(input logic neg);
        ref_a_o <= neg;
        ref_b_o <= neg;
        @(posedge clk_i);
    endtask
    // one step; sign settles a cycle ahead so no step sees a stale sign
    task automatic step(input logic neg, input logic two, input logic dn);
        if (!two) ref_b_o <= dn;
        @(posedge clk_i);
        if (two && dn) ref_b_o <= !neg;
        else ref_a_o <= !neg;
        @(posedge clk_i);
        if (two && dn) ref_b_o <= neg;
        else ref_a_o <= neg;
        @(posedge clk_i);
    endtask
    // clear held two samples so a level sense cannot miss it
    task automatic clr(input logic idl);
        clear_o <= !idl;
        repeat (2) @(posedge clk_i);
        clear_o <= idl;
        @(posedge clk_i);
    endtask
    // rest level matching the sense digit
    task automatic rest(input logic idl);
        clear_o <= idl;
        @(posedge clk_i);
    endtask
endmodule

// ### prec_top_bench.sv
// self-checking bench for prec_top, host model on the pulse pins
// assumes prec_pkg and prec_host are compiled first
`timescale 1ns/100ps
module prec_top_bench;
    logic clk_i, rst_i = 1'b1, ack, ref_a, ref_b, clr_in, err_clr;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic bb = 1'b0, alm = 1'b0, fb_up = 1'b0, fb_dn = 1'b0;
    logic clr_seen = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [3:0] fl [5] = '{4'h5, 4'h6, 4'h0, 4'h1, 4'h2};
    logic [31:0] wb_wr = 32'h0000_0000, wb_rd;
    logic signed [15:0] pos_err, exp_err = 16'sh0000;
    int bad_count = 0, total_checks = 0;
    prec_top prec_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wr), .wb_dat_o(wb_rd), .wb_ack_o(ack),
        .ref_a_i(ref_a), .ref_b_i(ref_b), .clear_in_i(clr_in),
        .baseblock_i(bb), .alarm_i(alm), .fb_up_i(fb_up), .fb_dn_i(fb_dn),
        .pos_err_o(pos_err), .err_clear_o(err_clr));
    prec_host prec_host_i (.clk_i(clk_i), .ref_a_o(ref_a), .ref_b_o(ref_b),
        .clear_o(clr_in));
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // latch any clear pulse; an edge clear stands one cycle only
    always @(posedge clk_i) if (err_clr === 1'b1) clr_seen <= 1'b1;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wr <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = wb_rd;
        if (n >= 20) bad_count++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic sel(input logic [3:0] op, cs, f);
        logic [31:0] r;
        wb(1'b1, 8'h00, {20'h0_0000, op, cs, f}, r);
    endtask
    // counting formats give one unit a step, others none
    function automatic logic signed [15:0] step_val(logic [3:0] f, logic dn);
        if (f != prec_pkg::PREC_FMT_SIGN_POS && f != prec_pkg::PREC_FMT_FR_POS
            && f != prec_pkg::PREC_FMT_SIGN_NEG
            && f != prec_pkg::PREC_FMT_FR_NEG) return 16'sh0000;
        return dn ? -16'sh0001 : 16'sh0001;
    endfunction
    function automatic logic auto_clr(logic [3:0] op, logic al);
        return op == prec_pkg::PREC_OP_BASEBLOCK ||
            (op == prec_pkg::PREC_OP_ALARM && al);
    endfunction
    // n steps; random ones add a feedback pulse after each
    task automatic run(input logic [3:0] f, input int n, input logic rnd);
        logic dn, up;
        repeat (n) begin
            dn = rnd ? 1'($urandom) : 1'b0;
            up = 1'($urandom);
            prec_host_i.step(f[2], f == 4'h1 || f == 4'h6, dn);
            exp_err = exp_err + step_val(f, dn);
            if (rnd) begin
                fb_up <= up;
                fb_dn <= !up;
                @(posedge clk_i);
                fb_up <= 1'b0;
                fb_dn <= 1'b0;
                exp_err = exp_err + (up ? -16'sh0001 : 16'sh0001);
            end
        end
    endtask
    // counter on the pins and through the status register
    task automatic chk_err();
        logic [31:0] r;
        repeat (2) @(posedge clk_i);
        chk("pos_err", 32'(exp_err), 32'(pos_err));
        wb(1'b0, 8'h04, 32'h0000_0000, r);
        chk("status count", {16'h0000, exp_err}, {16'h0000, r[15:0]});
    endtask
    initial begin
        logic [31:0] r;
        r = $urandom(52);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0000_0000, r);
        chk("select", {20'h0_0000, prec_pkg::PREC_SELECT_RST}, r);
        wb(1'b1, 8'h08, $urandom, r);
        wb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("unmapped", 32'h0000_0000, r);
        // lane 0 alone writes the low digits, auto-clear digit kept
        sel(4'h2, 4'h3, 4'h6);
        wb_sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h0000_0fff, r);
        wb_sel <= 4'hf;
        wb(1'b0, 8'h00, 32'h0000_0000, r);
        chk("lane write", 32'h0000_02ff, r);
        // each format, the refused one last
        foreach (fl[k]) begin
            sel(4'h1, 4'h0, fl[k]);
            prec_host_i.idle(fl[k][2]);
            prec_host_i.clr(1'b0);
            exp_err = 16'sh0000;
            run(fl[k], 10, 1'b1);
            chk_err();
        end
        // each clear sense, at rest first so no stray clear
        for (int s = 0; s < 4; s++) begin
            prec_host_i.rest(s[1]);
            sel(4'h1, 4'(s), 4'h5);
            prec_host_i.idle(1'b1);
            run(4'h5, 3, 1'b0);
            chk_err();
            clr_seen <= 1'b0;
            prec_host_i.clr(s[1]);
            exp_err = 16'sh0000;
            chk_err();
            chk("clear flag", 32'h0000_0001, {31'h0, clr_seen});
        end
        // each auto-clear digit against baseblock, then alarm
        for (int op = 0; op < 3; op++) begin
            sel(4'(op), 4'h1, 4'h5);
            for (int al = 0; al < 2; al++) begin
                run(4'h5, 3, 1'b0);
                bb <= 1'b1;
                alm <= al[0];
                // status read spans the same three edges of baseblock
                wb(1'b0, 8'h04, 32'h0000_0000, r);
                chk("flags", {30'h0, al[0], 1'b1}, {30'h0, r[18:17]});
                bb <= 1'b0;
                alm <= 1'b0;
                if (auto_clr(4'(op), al[0])) exp_err = 16'sh0000;
                chk_err();
            end
        end
        // mid-run reset: counter and select back to reset values
        prec_host_i.rest(1'b0);
        run(4'h5, 3, 1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        exp_err = 16'sh0000;
        chk_err();
        wb(1'b0, 8'h00, 32'h0000_0000, r);
        chk("reset select", {20'h0_0000, prec_pkg::PREC_SELECT_RST}, r);
        finish_test();
    end
    // watchdog well past the expected run length
    initial begin
        #200_000;
        bad_count++;
        finish_test();
    end
endmodule
